// File: design/rldac_pkg.sv
package rldac_pkg;

  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [11:0] RLDAC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] RLDAC_LEVEL_OFFSET = 12'h004;
  localparam logic [11:0] RLDAC_SLEEP_OFFSET = 12'h008;
  localparam logic [11:0] RLDAC_STATUS_OFFSET = 12'h00C;

  // ************************************************************
  // Field positions of the source and pin control register
  // ************************************************************
  localparam int RLDAC_EN_BIT = 7;
  localparam int RLDAC_OE1_BIT = 5;
  localparam int RLDAC_OE2_BIT = 4;
  localparam int RLDAC_PSS_LSB = 2;
  localparam int RLDAC_NSS_BIT = 0;
  localparam logic [7:0] RLDAC_CTRL_WMASK = 8'hBD;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RLDAC_CTRL_RESET = 8'h00;
  localparam logic [7:0] RLDAC_LEVEL_RESET = 8'h00;

  // ************************************************************
  // Positive source codes
  // ************************************************************
  typedef enum logic [1:0] {
    RLDAC_PSS_SUPPLY = 2'b00,
    RLDAC_PSS_VREF_PIN = 2'b01,
    RLDAC_PSS_FIXED_REF = 2'b10,
    RLDAC_PSS_RESERVED = 2'b11
  } rldac_pss_t;

  // ************************************************************
  // AHB-Lite encodings
  // ************************************************************
  localparam logic [1:0] RLDAC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] RLDAC_HSIZE_WORD = 3'h2;

endpackage

// File: design/rldac_top.sv
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns

// Functional notes
// - Converter active only while enable bit set
// - Eight-bit code selects one of 256 levels
// - Output equals bottom plus span times code/256
// - Top source: supply, reference pin, fixed buffer
// - Bottom source: reference pin or ground
// - Two enables connect level to each pin
// - Selected pin loses digital driver and detector
// - Digital read of selected pin returns zero
// - Converter keeps running during sleep
// - Wake from sleep keeps control register intact
// - Reset disables, removes pins, clears code
// - Bits six and one read zero
// - Output net feeds comparator, ADC, both pins
module rldac_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device sleep state
  input wire logic sleep_active,
  // Analog ladder control
  output logic ladder_active,
  output logic [7:0] ladder_tap,
  output rldac_pkg::rldac_pss_t top_source_select,
  output logic bottom_source_select,
  output logic tap_to_comparator,
  output logic tap_to_adc_channel,
  output logic tap_to_pin_one,
  output logic tap_to_pin_two,
  // Reference output pin one port logic
  input wire logic pin_one_port_out,
  input wire logic pin_one_port_oe,
  input wire logic pin_one_in,
  output logic pin_one_out,
  output logic pin_one_oe,
  output logic pin_one_digital_in,
  output logic pin_one_detector_enable,
  // Reference output pin two port logic
  input wire logic pin_two_port_out,
  input wire logic pin_two_port_oe,
  input wire logic pin_two_in,
  output logic pin_two_out,
  output logic pin_two_oe,
  output logic pin_two_digital_in,
  output logic pin_two_detector_enable
);
  import rldac_pkg::*;

  // ************************************************************
  // Bus address phase capture
  // ************************************************************
  logic wr_pend_q, wr_pend_d;
  logic [11:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic access;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] level_q, level_d;
  logic [7:0] write_byte;

  assign access = hsel && hready && (htrans == RLDAC_HTRANS_NONSEQ)
                  && (hsize == RLDAC_HSIZE_WORD);
  assign write_byte = hwdata[7:0];

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_comb begin
    wr_pend_d = access && hwrite;
    wr_addr_d = access ? haddr : wr_addr_q;
    hrdata_d = hrdata_q;
    if (access && !hwrite) begin
      case (haddr)
        RLDAC_CTRL_OFFSET: hrdata_d = {24'h000000, ctrl_q};
        RLDAC_LEVEL_OFFSET: hrdata_d = {24'h000000, level_q};
        RLDAC_SLEEP_OFFSET: hrdata_d = {31'h00000000, sleep_active};
        RLDAC_STATUS_OFFSET: hrdata_d = {28'h0000000, tap_to_pin_two,
                                         tap_to_pin_one, ladder_active, 1'b0};
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Sleep is deliberately not an input here: entering or leaving it
  // never touches these registers, so the ladder keeps its setting.
  always_comb begin
    ctrl_d = ctrl_q;
    level_d = level_q;
    if (wr_pend_q && wr_addr_q == RLDAC_CTRL_OFFSET) begin
      ctrl_d = write_byte & RLDAC_CTRL_WMASK;
    end
    if (wr_pend_q && wr_addr_q == RLDAC_LEVEL_OFFSET) begin
      level_d = write_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= RLDAC_CTRL_RESET;
      level_q <= RLDAC_LEVEL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      level_q <= level_d;
    end
  end

  // ************************************************************
  // Ladder steering
  // ************************************************************
  // The analog tap is bottom + span * code / 256; digital side only
  // supplies the code and the selects.
  assign ladder_active = ctrl_q[RLDAC_EN_BIT];
  assign ladder_tap = level_q;
  // Reserved code 11 is passed through unchanged; software avoids it
  assign top_source_select = rldac_pss_t'(ctrl_q[RLDAC_PSS_LSB +: 2]);
  assign bottom_source_select = ctrl_q[RLDAC_NSS_BIT];
  assign tap_to_comparator = ladder_active;
  assign tap_to_adc_channel = ladder_active;
  assign tap_to_pin_one = ctrl_q[RLDAC_OE1_BIT];
  assign tap_to_pin_two = ctrl_q[RLDAC_OE2_BIT];

  // ************************************************************
  // Pin override
  // ************************************************************
  // Selecting the pin for the reference wins over the port driver
  assign pin_one_oe = pin_one_port_oe && !tap_to_pin_one;
  assign pin_one_out = tap_to_pin_one ? 1'b0 : pin_one_port_out;
  assign pin_one_detector_enable = !tap_to_pin_one;
  assign pin_one_digital_in = pin_one_in && !tap_to_pin_one;
  assign pin_two_oe = pin_two_port_oe && !tap_to_pin_two;
  assign pin_two_out = tap_to_pin_two ? 1'b0 : pin_two_port_out;
  assign pin_two_detector_enable = !tap_to_pin_two;
  assign pin_two_digital_in = pin_two_in && !tap_to_pin_two;

endmodule

// File: verif/rldac_checker.sv
`timescale 1ns/1ns
// ********
// Write effects and pin override
// ********
module rldac_checker import rldac_pkg::*; (
  // Bus
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  // Ladder and pin one
  input wire logic ladder_active,
  input wire logic [7:0] ladder_tap,
  input wire logic tap_to_comparator,
  input wire logic tap_to_pin_one,
  input wire logic pin_one_oe,
  input wire logic pin_one_digital_in,
  input wire logic pin_one_detector_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Address phase then the data phase that carries hwdata
  sequence s_wr(logic [11:0] a);
    hsel && hreadyout && hwrite && htrans == RLDAC_HTRANS_NONSEQ && hsize == RLDAC_HSIZE_WORD
      && haddr == a ##1 1'b1;
  endsequence
  AST_EN: assert property (s_wr(RLDAC_CTRL_OFFSET) |=> ladder_active == $past(hwdata[7]))
    else $error("enable not taken from write");
  AST_PIN: assert property (s_wr(RLDAC_CTRL_OFFSET) |=> tap_to_pin_one == $past(hwdata[5]))
    else $error("pin one connect not taken from write");
  AST_LVL: assert property (s_wr(RLDAC_LEVEL_OFFSET) |=> ladder_tap == $past(hwdata[7:0]))
    else $error("level code not taken from write");
  AST_CMP: assert property (tap_to_comparator == ladder_active)
    else $error("comparator feed differs from enable");
  AST_OE: assert property (tap_to_pin_one |-> !pin_one_oe)
    else $error("pin one driver active while tapped");
  AST_DET: assert property (tap_to_pin_one |-> !pin_one_detector_enable)
    else $error("pin one detector active while tapped");
  AST_RD0: assert property (tap_to_pin_one |-> !pin_one_digital_in)
    else $error("pin one reads high while tapped");
  AST_RST: assert property ($fell(reset) |-> !ladder_active && ladder_tap == 8'h00)
    else $error("ladder not cleared by reset");
endmodule

bind rldac_top rldac_checker u_chk (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hreadyout, .ladder_active, .ladder_tap, .tap_to_comparator, .tap_to_pin_one,
  .pin_one_oe, .pin_one_digital_in, .pin_one_detector_enable);

// File: verif/rldac_top_bench.sv
`timescale 1ns/1ns
module rldac_top_bench;
  import rldac_pkg::*;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, sleep_active = 0, rd_dp = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = RLDAC_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0, hrdata, q[$];
  logic p1o = 1, p1e = 1, p1i = 1, p2o = 1, p2e = 1, p2i = 1;
  logic hready, hreadyout, hresp, ladder_active, bottom_source_select, tap_to_comparator;
  logic tap_to_adc_channel, tap_to_pin_one, tap_to_pin_two, pin_one_out, pin_one_oe;
  logic pin_one_digital_in, pin_one_detector_enable, pin_two_out, pin_two_oe;
  logic pin_two_digital_in, pin_two_detector_enable;
  logic [7:0] ladder_tap, c, v;
  rldac_pss_t top_source_select;
  int err_total = 0, n_checks = 0;
  assign hready = hreadyout;
  rldac_top DUT (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sleep_active, .ladder_active, .ladder_tap, .top_source_select,
    .bottom_source_select, .tap_to_comparator, .tap_to_adc_channel, .tap_to_pin_one,
    .tap_to_pin_two, .pin_one_port_out(p1o), .pin_one_port_oe(p1e), .pin_one_in(p1i),
    .pin_one_out, .pin_one_oe, .pin_one_digital_in, .pin_one_detector_enable,
    .pin_two_port_out(p2o), .pin_two_port_oe(p2e), .pin_two_in(p2i), .pin_two_out,
    .pin_two_oe, .pin_two_digital_in, .pin_two_detector_enable);
  initial forever #25 clk = ~clk;
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      print_verdict;
    end
  endtask
  task bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1;
    hwrite <= w;
    haddr <= a;
    htrans <= RLDAC_HTRANS_NONSEQ;
    rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    rdy;
    rd_dp <= 0;
  endtask
  task rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  // Upper data bits are random since only the low byte counts
  task wr(logic [11:0] a, logic [7:0] d);
    bus(1, a, {24'($urandom), d});
  endtask
  always @(posedge clk) if (rd_dp) chk("hrdata", q.pop_front(), hrdata);
  initial begin
    void'($urandom(32'h04F3));
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(RLDAC_CTRL_OFFSET, 0);
    wr(RLDAC_CTRL_OFFSET, 8'hFF);
    rd(RLDAC_CTRL_OFFSET, 32'hBD);
    for (int i = 0; i < 12; i++) begin
      c = 8'($urandom) & RLDAC_CTRL_WMASK;
      c[3:2] = 2'(i % 3);
      {p1i, p2i, p1e, p2e, p1o, p2o} <= 6'($urandom);
      wr(RLDAC_CTRL_OFFSET, c);
      // Register outputs settle after the edge that ends the write
      @(negedge clk);
      chk("pss", c[3:2], top_source_select);
      chk("nss", c[0], bottom_source_select);
      chk("adc", c[7], tap_to_adc_channel);
      chk("pin2", c[4], tap_to_pin_two);
      chk("oe2", p2e & !c[4], pin_two_oe);
      chk("out2", p2o & !c[4], pin_two_out);
      chk("det2", !c[4], pin_two_detector_enable);
      chk("out1", p1o & !c[5], pin_one_out);
      chk("din2", p2i & !c[4], pin_two_digital_in);
      @(posedge clk);
      v = (i == 11) ? 8'hFF : 8'($urandom);
      wr(RLDAC_LEVEL_OFFSET, v);
      rd(RLDAC_LEVEL_OFFSET, v);
      chk("tap", v, ladder_tap);
    end
    rd(RLDAC_STATUS_OFFSET, {28'h0, c[4], c[5], c[7], 1'b0});
    // Ladder left as set before sleep; disabling it is only advised
    sleep_active <= 1;
    rd(RLDAC_SLEEP_OFFSET, 1);
    chk("sleep_en", c[7], ladder_active);
    sleep_active <= 0;
    rd(RLDAC_CTRL_OFFSET, c);
    wr(12'h010, 8'hFF);
    rd(12'h010, 0);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    rd(RLDAC_LEVEL_OFFSET, 0);
    chk("pin2_rst", 0, tap_to_pin_two);
    print_verdict;
  end
endmodule
